/* File: sdlc_cfg_pkg.sv */
// Purpose: Shared constants and types for the serial link mode configuration block.
// Assumes: Eight-bit command and parameter bytes from the host.
// Notes: Mode registers are write-only from the host side.
package sdlc_cfg_pkg;
    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_SET_OPER = 8'h91;
    localparam logic [7:0] CMD_CLR_OPER = 8'h51;
    localparam logic [7:0] CMD_SET_XFER = 8'h97;
    localparam logic [7:0] CMD_CLR_XFER = 8'h57;
    localparam logic [7:0] CMD_SET_SIO = 8'ha0;
    localparam logic [7:0] CMD_CLR_SIO = 8'h60;
    localparam logic [7:0] CMD_SET_DLY = 8'ha4;
    localparam logic [7:0] CMD_CLR_DLY = 8'h64;
    // ==========================================================
    // Register selects
    localparam logic [1:0] SEL_OPER = 2'h0;
    localparam logic [1:0] SEL_SIO = 2'h1;
    localparam logic [1:0] SEL_XFER = 2'h2;
    localparam logic [1:0] SEL_DLY = 2'h3;
    // ==========================================================
    // Field positions
    localparam int OPER_HDLC_ABORT = 5;
    localparam int OPER_EOP_IRQ = 4;
    localparam int OPER_EARLY_TX = 3;
    localparam int OPER_BUFFERED = 2;
    localparam int OPER_PREFRAME = 1;
    localparam int OPER_FLAG_STREAM = 0;
    localparam int SIO_DATA_LOOP = 2;
    localparam int SIO_CLOCK_LOOP = 1;
    localparam int SIO_NRZI = 0;
    localparam int XFER_IRQ = 0;
    localparam int DLY_ENABLE = 7;
    // ==========================================================
    // Reset values, characters and counts
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] FLAG_CHAR = 8'h7e;
    localparam logic [7:0] IDLE_CHAR = 8'hff;
    localparam logic [7:0] SYNC_PLAIN = 8'h55;
    localparam logic [7:0] SYNC_NRZI = 8'h00;
    localparam logic [3:0] ABORT_HDLC_ONES = 4'h7;
    localparam logic [3:0] ABORT_SDLC_ONES = 4'h8;
    localparam logic [3:0] EOP_ONES = 4'h7;
    localparam logic [3:0] IDLE_ONES = 4'hf;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef struct packed {
        logic [7:0] oper;
        logic [7:0] sio;
        logic [7:0] xfer;
        logic [7:0] dly;
    } mode_s;

    typedef enum {ST_IDLE, ST_WAIT_PARAM, ST_APPLY} cmd_state_e;
endpackage : sdlc_cfg_pkg

/* File: pin_sync.sv */
// Purpose: Two-stage synchroniser for pins from outside the core clock domain.
// Assumes: Inputs are levels; multi-bit inputs are held stable around strobes.
// Notes: Only the second stage leaves this module.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic core_clk, // core clock
    input wire logic arst_n, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous pin levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule : pin_sync

/* File: sdlc_mode_config.sv */
// Purpose: Command/parameter front end and the four mode registers of a serial link controller.
// Assumes: Host strobes and data are asynchronous pins; transmitter/receiver cores share core_clk.
// Notes: Bit clocks are sampled by core_clk and must be well below a quarter of its rate.
`timescale 1ns/1ps

module sdlc_mode_config (
    input wire logic core_clk, // core clock, 40 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic [7:0] host_din, // host data bus
    input wire logic cmd_wr_n, // command write strobe, active low
    input wire logic param_wr_n, // parameter write strobe, active low
    input wire logic transmit_bit_clock, // transmit bit clock pin
    input wire logic receive_bit_clock, // receive bit clock pin
    input wire logic rx_line, // receive data pin
    input wire logic tx_active, // transmitter core is sending a frame
    input wire logic tx_core_bit, // frame bit from the transmitter core
    input wire logic xfer_req, // a data byte transfer is due
    input wire logic result_pending, // a result byte is waiting
    output logic command_busy_flag, // command phase in progress
    output logic parameter_full_flag, // parameter byte not yet consumed
    output sdlc_cfg_pkg::mode_s mode, // the four mode registers
    output logic other_cmd_valid, // pulse: non-configuration command taken
    output logic [7:0] other_cmd, // that command byte
    output logic [7:0] preframe_char, // sync character to send before a frame
    output logic tx_line, // transmit data pin
    output logic rx_bit_valid, // pulse: decoded receive bit ready
    output logic rx_bit, // decoded receive bit
    output logic abort_event, // pulse: abort seen
    output logic eop_event, // pulse: end-of-poll seen
    output logic idle_event, // pulse: fifteen ones seen
    output logic dma_request_pin, // DMA transfer request
    output logic data_irq, // interrupt-driven transfer request
    output logic result_available_flag // result rather than data transfer
);
    // ==========================================================
    // Pin synchronisers
    logic [11:0] pins_q;
    logic [7:0] din_q;
    logic cmd_q, param_q, txc_q, rxc_q, rxd_q;
    logic cmd_d1, param_d1, txc_d1, rxck_d1;

    pin_sync #(.W(12)) u_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .d({host_din, ~cmd_wr_n, ~param_wr_n, transmit_bit_clock, receive_bit_clock}),
        .q(pins_q)
    );
    pin_sync #(.W(1)) u_sync_rxd (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .d(rx_line),
        .q(rxd_q)
    );

    always_comb begin
        din_q = pins_q[11:4];
        cmd_q = pins_q[3];
        param_q = pins_q[2];
        txc_q = pins_q[1];
        rxc_q = pins_q[0];
    end

    // Strobes are carried active high, so the synchroniser's reset level is their idle level and
    // no false take follows reset. The trailing edge of a write strobe takes the byte.
    logic cmd_take, param_take, txc_rise, rxc_sel, rxc_rise;
    assign cmd_take = ~cmd_q & cmd_d1;
    assign param_take = ~param_q & param_d1;
    assign txc_rise = txc_q & ~txc_d1;
    assign rxc_sel = mode.sio[sdlc_cfg_pkg::SIO_CLOCK_LOOP] ? txc_q : rxc_q;
    assign rxc_rise = rxc_sel & ~rxck_d1;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_d1 <= 1'b0;
            param_d1 <= 1'b0;
            txc_d1 <= 1'b0;
            rxck_d1 <= 1'b0;
        end else begin
            cmd_d1 <= cmd_q;
            param_d1 <= param_q;
            txc_d1 <= txc_q;
            rxck_d1 <= rxc_sel;
        end
    end

    // ==========================================================
    // Command decode
    // Returns {is_config, is_set, select}.
    function automatic logic [3:0] cfg_decode(input logic [7:0] c);
        logic [3:0] r;
        r = 4'h0;
        if (c == sdlc_cfg_pkg::CMD_SET_OPER) r = {2'b11, sdlc_cfg_pkg::SEL_OPER};
        else if (c == sdlc_cfg_pkg::CMD_CLR_OPER) r = {2'b10, sdlc_cfg_pkg::SEL_OPER};
        else if (c == sdlc_cfg_pkg::CMD_SET_XFER) r = {2'b11, sdlc_cfg_pkg::SEL_XFER};
        else if (c == sdlc_cfg_pkg::CMD_CLR_XFER) r = {2'b10, sdlc_cfg_pkg::SEL_XFER};
        else if (c == sdlc_cfg_pkg::CMD_SET_SIO) r = {2'b11, sdlc_cfg_pkg::SEL_SIO};
        else if (c == sdlc_cfg_pkg::CMD_CLR_SIO) r = {2'b10, sdlc_cfg_pkg::SEL_SIO};
        else if (c == sdlc_cfg_pkg::CMD_SET_DLY) r = {2'b11, sdlc_cfg_pkg::SEL_DLY};
        else if (c == sdlc_cfg_pkg::CMD_CLR_DLY) r = {2'b10, sdlc_cfg_pkg::SEL_DLY};
        return r;
    endfunction : cfg_decode

    function automatic logic [7:0] apply_mask(input logic [7:0] cur, input logic set, input logic [7:0] m);
        return set ? (cur | m) : (cur & m);
    endfunction : apply_mask

    // ==========================================================
    // Command phase and mode registers
    sdlc_cfg_pkg::cmd_state_e state, next_state;
    logic [3:0] cfg_op, next_cfg_op, dec;
    logic [7:0] param, next_param, next_other_cmd;
    logic next_busy, next_pfull, next_other_valid;
    sdlc_cfg_pkg::mode_s next_mode;

    always_comb begin
        dec = cfg_decode(din_q);
        next_state = state;
        next_cfg_op = cfg_op;
        next_param = param;
        next_busy = command_busy_flag;
        next_pfull = parameter_full_flag;
        next_mode = mode;
        next_other_valid = 1'b0;
        next_other_cmd = other_cmd;
        case (state)
            sdlc_cfg_pkg::ST_WAIT_PARAM: begin
                if (param_take) begin
                    next_param = din_q;
                    next_pfull = 1'b1;
                    next_state = sdlc_cfg_pkg::ST_APPLY;
                end
            end
            sdlc_cfg_pkg::ST_APPLY: begin
                // Only now, with the mask in hand, does a register change.
                case (cfg_op[1:0])
                    sdlc_cfg_pkg::SEL_OPER: next_mode.oper = apply_mask(mode.oper, cfg_op[2], param);
                    sdlc_cfg_pkg::SEL_SIO: next_mode.sio = apply_mask(mode.sio, cfg_op[2], param);
                    sdlc_cfg_pkg::SEL_XFER: next_mode.xfer = apply_mask(mode.xfer, cfg_op[2], param);
                    default: next_mode.dly = apply_mask(mode.dly, cfg_op[2], param);
                endcase
                // No event and no result byte is produced here.
                next_busy = 1'b0;
                next_pfull = param_take; // Set wins over the consuming clear.
                next_state = sdlc_cfg_pkg::ST_IDLE;
            end
            default: begin
                // Parameters of other commands belong to the cores; drop the flag next cycle.
                next_pfull = param_take;
                if (param_take) next_param = din_q;
            end
        endcase
        // A new command overwrites whatever phase was running.
        if (cmd_take) begin
            if (dec[3]) begin
                next_cfg_op = dec;
                next_busy = 1'b1;
                next_pfull = 1'b0;
                next_state = sdlc_cfg_pkg::ST_WAIT_PARAM;
            end else begin
                next_other_valid = 1'b1;
                next_other_cmd = din_q;
                next_busy = 1'b0;
                next_state = sdlc_cfg_pkg::ST_IDLE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= sdlc_cfg_pkg::ST_IDLE;
            cfg_op <= 4'h0;
            param <= 8'h00;
            command_busy_flag <= 1'b0;
            parameter_full_flag <= 1'b0;
            mode <= {4{sdlc_cfg_pkg::MODE_RESET}};
            other_cmd_valid <= 1'b0;
            other_cmd <= 8'h00;
        end else begin
            state <= next_state;
            cfg_op <= next_cfg_op;
            param <= next_param;
            command_busy_flag <= next_busy;
            parameter_full_flag <= next_pfull;
            mode <= next_mode;
            other_cmd_valid <= next_other_valid;
            other_cmd <= next_other_cmd;
        end
    end

    // ==========================================================
    // Receive path
    logic raw_prev, next_raw_prev, dly_active, next_dly_active, raw_in, dec_bit;
    logic [3:0] ones, next_ones, abort_ones;
    logic [2:0] rx_cnt, next_rx_cnt;
    logic next_rx_bit_valid, next_rx_bit, next_abort, next_eop, next_idle;

    always_comb begin
        raw_in = mode.sio[sdlc_cfg_pkg::SIO_DATA_LOOP] ? tx_line : rxd_q;
        dec_bit = mode.sio[sdlc_cfg_pkg::SIO_NRZI] ? (raw_in == raw_prev) : raw_in;
        abort_ones = mode.oper[sdlc_cfg_pkg::OPER_HDLC_ABORT] ? sdlc_cfg_pkg::ABORT_HDLC_ONES
                                                              : sdlc_cfg_pkg::ABORT_SDLC_ONES;
        next_raw_prev = raw_prev;
        next_ones = ones;
        next_rx_cnt = rx_cnt;
        next_dly_active = dly_active;
        next_rx_bit_valid = 1'b0;
        next_rx_bit = rx_bit;
        next_abort = 1'b0;
        next_eop = 1'b0;
        next_idle = 1'b0;
        if (rxc_rise) begin
            next_raw_prev = raw_in;
            next_rx_bit_valid = 1'b1;
            next_rx_bit = dec_bit;
            next_rx_cnt = 3'(rx_cnt + 3'h1);
            // Delay mode changes state only at a received character boundary.
            if (rx_cnt == sdlc_cfg_pkg::LAST_BIT) next_dly_active = mode.dly[sdlc_cfg_pkg::DLY_ENABLE];
            if (!dec_bit) begin
                next_ones = 4'h0;
            end else if (ones != sdlc_cfg_pkg::IDLE_ONES) begin
                next_ones = 4'(ones + 4'h1);
                next_abort = (4'(ones + 4'h1) == abort_ones);
                next_eop = mode.oper[sdlc_cfg_pkg::OPER_EOP_IRQ] && (4'(ones + 4'h1) == sdlc_cfg_pkg::EOP_ONES);
                next_idle = (4'(ones + 4'h1) == sdlc_cfg_pkg::IDLE_ONES);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            raw_prev <= 1'b0;
            ones <= 4'h0;
            rx_cnt <= 3'h0;
            dly_active <= 1'b0;
            rx_bit_valid <= 1'b0;
            rx_bit <= 1'b0;
            abort_event <= 1'b0;
            eop_event <= 1'b0;
            idle_event <= 1'b0;
        end else begin
            raw_prev <= next_raw_prev;
            ones <= next_ones;
            rx_cnt <= next_rx_cnt;
            dly_active <= next_dly_active;
            rx_bit_valid <= next_rx_bit_valid;
            rx_bit <= next_rx_bit;
            abort_event <= next_abort;
            eop_event <= next_eop;
            idle_event <= next_idle;
        end
    end

    // ==========================================================
    // Transmit line, idle fill and transfer routing
    logic [7:0] fill, next_fill, next_preframe;
    logic [2:0] tx_cnt, next_tx_cnt;
    logic next_tx_line, next_dma, next_dirq, next_raf, tx_bit;

    always_comb begin
        next_fill = fill;
        next_tx_cnt = tx_cnt;
        next_tx_line = tx_line;
        tx_bit = tx_active ? tx_core_bit : fill[0];
        if (dly_active) begin
            // Retransmit the raw line level sampled at each receive bit clock rise, one core cycle later.
            if (rxc_rise) next_tx_line = raw_in;
        end else if (txc_rise) begin
            next_tx_cnt = 3'(tx_cnt + 3'h1);
            next_fill = {1'b0, fill[7:1]};
            // A new fill character is chosen only at a character boundary.
            if (tx_cnt == sdlc_cfg_pkg::LAST_BIT) begin
                next_tx_cnt = 3'h0;
                next_fill = mode.oper[sdlc_cfg_pkg::OPER_FLAG_STREAM] ? sdlc_cfg_pkg::FLAG_CHAR
                                                                       : sdlc_cfg_pkg::IDLE_CHAR;
            end
            if (mode.sio[sdlc_cfg_pkg::SIO_NRZI]) next_tx_line = tx_bit ? tx_line : ~tx_line;
            else next_tx_line = tx_bit;
        end
        next_preframe = mode.sio[sdlc_cfg_pkg::SIO_NRZI] ? sdlc_cfg_pkg::SYNC_NRZI
                                                          : sdlc_cfg_pkg::SYNC_PLAIN;
        next_dma = xfer_req & ~mode.xfer[sdlc_cfg_pkg::XFER_IRQ];
        next_dirq = xfer_req & mode.xfer[sdlc_cfg_pkg::XFER_IRQ];
        next_raf = result_pending & ~next_dirq;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fill <= sdlc_cfg_pkg::IDLE_CHAR;
            tx_cnt <= 3'h0;
            tx_line <= 1'b1;
            preframe_char <= sdlc_cfg_pkg::SYNC_PLAIN;
            dma_request_pin <= 1'b0;
            data_irq <= 1'b0;
            result_available_flag <= 1'b0;
        end else begin
            fill <= next_fill;
            tx_cnt <= next_tx_cnt;
            tx_line <= next_tx_line;
            preframe_char <= next_preframe;
            dma_request_pin <= next_dma;
            data_irq <= next_dirq;
            result_available_flag <= next_raf;
        end
    end
endmodule : sdlc_mode_config

/* File: sdlc_mode_config_properties.sv */
// Purpose: Port checks for the mode configuration block.
// Assumes: One clock domain and an asynchronous active-low reset.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module sdlc_mode_config_checker (
    input wire logic core_clk, // clock
    input wire logic arst_n, // reset, active low
    input wire logic command_busy_flag, // busy
    input wire logic parameter_full_flag, // parameter held
    input wire sdlc_cfg_pkg::mode_s mode, // mode registers
    input wire logic other_cmd_valid, // other command
    input wire logic [7:0] preframe_char, // sync character
    input wire logic abort_event, // abort
    input wire logic eop_event, // end of poll
    input wire logic data_irq, // transfer interrupt
    input wire logic dma_request_pin // transfer request
);
    // ==========================================
    // Assertions
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_reset_clears_modes: assert property (!$past(arst_n) |-> mode == 32'h0)
        else $error("mode not clear after reset");
    a_change_after_param: assert property ($changed(mode) |-> $past(parameter_full_flag))
        else $error("mode changed without a parameter");
    a_apply_ends_cmd: assert property ($rose(parameter_full_flag) && command_busy_flag
        |=> !command_busy_flag && !parameter_full_flag)
        else $error("command phase did not close");
    a_busy_no_other: assert property (command_busy_flag |-> !other_cmd_valid)
        else $error("config command passed on");
    a_eop_needs_bit: assert property (eop_event |-> $past(mode.oper[4]))
        else $error("end of poll while disabled");
    a_short_abort: assert property (eop_event && $past(mode.oper[5]) |-> abort_event)
        else $error("seven ones gave no abort");
    a_irq_transfer: assert property (data_irq |-> mode.xfer[0] || $past(mode.xfer[0]))
        else $error("interrupt request in DMA mode");
    a_dma_transfer: assert property (dma_request_pin |-> !mode.xfer[0] || !$past(mode.xfer[0]))
        else $error("DMA request in interrupt mode");
    a_sync_char: assert property ($stable(mode.sio) [*2]
        |-> preframe_char == (mode.sio[0] ? 8'h00 : 8'h55))
        else $error("wrong sync character");
endmodule : sdlc_mode_config_checker

bind sdlc_mode_config sdlc_mode_config_checker u_chk (.core_clk(core_clk), .arst_n(arst_n),
    .command_busy_flag(command_busy_flag), .parameter_full_flag(parameter_full_flag), .mode(mode),
    .other_cmd_valid(other_cmd_valid), .preframe_char(preframe_char), .abort_event(abort_event),
    .eop_event(eop_event), .data_irq(data_irq), .dma_request_pin(dma_request_pin));

/* File: host_cpu_model.sv */
// Purpose: Host processor that writes command and mask bytes.
// Assumes: Strobes stay low and high for at least three core cycles.
// Notes: The bus is inverted once released, so a stale byte never looks held.
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic core_clk, // clock
    input wire logic command_busy_flag, // device busy
    input wire logic parameter_full_flag, // parameter held
    output logic [7:0] host_din, // data bus
    output logic cmd_wr_n, // command strobe, active low
    output logic param_wr_n // parameter strobe, active low
);
    int stalls = 0;
    initial begin
        host_din = 8'h00;
        cmd_wr_n = 1'b1;
        param_wr_n = 1'b1;
    end
    // ==========================================
    // Byte write
    task automatic put(input logic [7:0] b, input bit prm);
        int n;
        n = 0;
        while ((prm ? parameter_full_flag : command_busy_flag) !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 200) stalls++;
        host_din <= b;
        repeat (2) @(posedge core_clk);
        if (prm) param_wr_n <= 1'b0;
        else cmd_wr_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        param_wr_n <= 1'b1;
        cmd_wr_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        host_din <= ~b;
        @(posedge core_clk);
    endtask : put
endmodule : host_cpu_model

/* File: tb_sdlc_mode_config.sv */
// Purpose: Self-checking bench for the mode configuration block.
// Assumes: Transmitter core inputs stay quiet.
// Notes: Link bit clocks run at 200 ns only while a stream is sent.
`timescale 1ns/1ps
module tb_sdlc_mode_config;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic tclk = 1'b0;
    logic rclk = 1'b0;
    logic link_on = 1'b0;
    logic rx_line = 1'b0;
    logic xfer_req = 1'b0;
    logic [7:0] host_din;
    logic cmd_wr_n;
    logic param_wr_n;
    logic command_busy_flag;
    logic parameter_full_flag;
    logic [7:0] other_cmd;
    logic [7:0] preframe_char;
    logic abort_event;
    logic eop_event;
    logic idle_event;
    logic data_irq;
    logic dma_request_pin;
    sdlc_cfg_pkg::mode_s mode;
    int n_mismatch = 0;
    int total_checks = 0;
    int n_ab;
    int n_eop;
    int n_idl;
    // Command, mask, expected modes; unused mask bits are 0 for set and 1 for reset.
    logic [47:0] rows [8] = '{
        48'h91_3f_3f000000,
        48'h51_f7_37000000,
        48'ha0_07_37070000,
        48'h60_f8_37000000,
        48'h97_01_37000100,
        48'h57_fe_37000000,
        48'ha4_80_37000080,
        48'h64_7f_37000000};
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #37;
        forever #100 if (link_on) tclk = ~tclk;
    end
    initial begin
        #61;
        forever #100 if (link_on) rclk = ~rclk;
    end
    always @(posedge core_clk) begin
        if (abort_event === 1'b1) n_ab++;
        if (eop_event === 1'b1) n_eop++;
        if (idle_event === 1'b1) n_idl++;
    end
    host_cpu_model host (.core_clk(core_clk), .command_busy_flag(command_busy_flag),
        .parameter_full_flag(parameter_full_flag), .host_din(host_din), .cmd_wr_n(cmd_wr_n),
        .param_wr_n(param_wr_n));
    sdlc_mode_config dut (.core_clk(core_clk), .arst_n(arst_n), .host_din(host_din), .cmd_wr_n(cmd_wr_n),
        .param_wr_n(param_wr_n), .transmit_bit_clock(tclk), .receive_bit_clock(rclk), .rx_line(rx_line),
        .tx_active(1'b0), .tx_core_bit(1'b0), .xfer_req(xfer_req), .result_pending(1'b0),
        .command_busy_flag(command_busy_flag), .parameter_full_flag(parameter_full_flag), .mode(mode),
        .other_cmd_valid(), .other_cmd(other_cmd), .preframe_char(preframe_char), .tx_line(),
        .rx_bit_valid(), .rx_bit(), .abort_event(abort_event), .eop_event(eop_event), .idle_event(idle_event),
        .dma_request_pin(dma_request_pin), .data_irq(data_irq), .result_available_flag());
    // ==========================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic give_verdict;
        n_mismatch += host.stalls;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic cfg(input logic [7:0] c, input logic [7:0] m);
        int n;
        host.put(c, 1'b0);
        host.put(m, 1'b1);
        n = 0;
        while (command_busy_flag !== 1'b0 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 50 || host.stalls > 0) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : cfg
    // Zeros, a run of ones, zeros; a run of exactly seven tells the two abort lengths apart.
    task automatic stream(input int ones, input int exp_ab, input int exp_eop, input int exp_idl);
        int i;
        n_ab = 0;
        n_eop = 0;
        n_idl = 0;
        link_on = 1'b1;
        for (i = 0; i < ones + 6; i++) begin
            @(negedge rclk);
            @(posedge core_clk);
            rx_line <= (i >= 3 && i < ones + 3);
        end
        @(negedge rclk);
        link_on = 1'b0;
        repeat (20) @(posedge core_clk);
        chk("abort count", n_ab, exp_ab);
        chk("poll count", n_eop, exp_eop);
        chk("idle count", n_idl, exp_idl);
        $display("stream of %0d ones done", ones);
    endtask : stream
    // ==========================================
    // Sequence
    initial begin
        int i;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        chk("mode after reset", mode, 32'h0);
        chk("sync char", preframe_char, 8'h55);
        xfer_req <= 1'b1;
        for (i = 0; i < 8; i++) begin
            cfg(rows[i][47:40], rows[i][39:32]);
            @(posedge core_clk);
            chk("mode", mode, rows[i][31:0]);
            @(negedge core_clk);
            chk("transfer irq", data_irq, rows[i][8]);
            chk("dma request", dma_request_pin, !rows[i][8]);
        end
        $display("table done");
        stream(7, 1, 1, 0);
        cfg(8'h51, 8'hcf);
        stream(7, 0, 0, 0);
        stream(8, 1, 0, 0);
        stream(16, 1, 0, 1);
        host.put(8'hc5, 1'b0);
        repeat (6) @(posedge core_clk);
        chk("other command", other_cmd, 8'hc5);
        chk("mode kept", mode, 32'h07000000);
        $display("other command done");
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("mode in reset", mode, 32'h0);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("other after reset", other_cmd, 8'h00);
        chk("busy after reset", command_busy_flag, 1'b0);
        $display("second reset done");
        give_verdict();
    end
endmodule : tb_sdlc_mode_config
